// ===== adcs_params.svh
/*
  Constants for the converter status register and its serial read port:
  field positions, reset values, command codes and transfer lengths.
  Assumes it is included by bare name from the design files.
*/
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// register select codes
`define ADCS_SEL_STATUS      3'h0
`define ADCS_SEL_DATA        3'h1

// status field positions
`define ADCS_BIT_READY       7
`define ADCS_BIT_SETTLED     6
`define ADCS_BIT_STANDBY     5
`define ADCS_BIT_MISSING_REFERENCE_FLAG       4

// reset values
`define ADCS_RST_READY       1'b1
`define ADCS_RST_SETTLED     1'b1
`define ADCS_RST_STANDBY     1'b0
`define ADCS_RST_MISSING_REFERENCE_FLAG       1'b0

// transfer mode field codes
`define ADCS_XFER_WRITE      2'h0
`define ADCS_XFER_SINGLE     2'h1
`define ADCS_XFER_CONT       2'h2
`define ADCS_XFER_STOP       2'h3

// operating mode field value that means standby
`define ADCS_MODE_STANDBY    3'h3

// continuous read stop code
`define ADCS_STOP_CODE       8'h30

// transfer lengths in serial clocks
`define ADCS_LEN_STATUS      5'h08
`define ADCS_LEN_SHORT       5'h10
`define ADCS_LEN_LONG        5'h18
`define ADCS_LEN_WRITE       5'h10

`endif

// ===== adcs_pkg.sv
/*
  Types shared by the status register core and its serial port.
  Assumes adcs_params.svh carries the numeric constants.
*/
package adcs_pkg;

  // serial port sequencing
  typedef enum logic [1:0] {
    LS_CMD_WAIT,
    LS_CMD_BITS,
    LS_READ,
    LS_WRITE
  } adcs_link_state_t;

endpackage

// ===== adcs_link_port.sv
/*
  Serial port of the converter, clocked by the host's serial clock.
  Takes command words, runs single and continuous reads of status and
  data, skips write payloads. Assumes the core holds the snapshot stable
  from a few core clocks after each snapshot request until the next one.
*/
`timescale 1ns/1ps
`include "adcs_params.svh"

module adcs_link_port
  import adcs_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input  wire logic              sclk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              din,
  output logic                   dout,
  input  wire logic [7:0]        snap_status,
  input  wire logic [DATA_W-1:0] snap_data,
  input  wire logic              snap_wl24,
  output logic                   snap_req_tgl,
  output logic                   data_read_tgl
);

  logic             rst_m_q, rst_s_q, ce_m_q, ce_s_q;
  adcs_link_state_t state_q, state_d;
  logic [6:0]       cmd_q, cmd_d, cmd_w, hist_q, hist_d;
  logic [4:0]       cnt_q, cnt_d, load_len;
  logic [2:0]       rs_q, rs_d;
  logic             cont_q, cont_d, first_q, first_d;
  logic [23:0]      sh_q, sh_d, load_word;
  logic             dout_q, dout_d, req_q, req_d, rdd_q, rdd_d;

  // reset and clock enable brought into the serial clock domain
  always_ff @(posedge sclk) begin
    rst_m_q <= resetn;
    rst_s_q <= rst_m_q;
    ce_m_q  <= ce;
    ce_s_q  <= ce_m_q;
  end

  assign cmd_w = {cmd_q[5:0], din};

  // word and length presented at the first clock of a read
  always_comb begin
    load_word = 24'h000000;
    load_len  = `ADCS_LEN_SHORT;
    if (rs_q == `ADCS_SEL_STATUS) begin
      load_word = {snap_status, 16'h0000};
      load_len  = `ADCS_LEN_STATUS;
    end else if (rs_q == `ADCS_SEL_DATA) begin
      load_word = 24'(snap_data);
      load_len  = snap_wl24 ? `ADCS_LEN_LONG : `ADCS_LEN_SHORT;
    end
  end

  // next state of the command and shift sequencer
  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    cnt_d   = cnt_q;
    rs_d    = rs_q;
    cont_d  = cont_q;
    first_d = first_q;
    sh_d    = sh_q;
    hist_d  = hist_q;
    dout_d  = dout_q;
    req_d   = req_q;
    rdd_d   = rdd_q;
    case (state_q)
      LS_CMD_WAIT: begin
        dout_d = 1'b0;
        if (!din) begin
          state_d = LS_CMD_BITS;
          cnt_d   = 5'h06;
        end
      end
      LS_CMD_BITS: begin
        cmd_d = cmd_w;
        if (cnt_q == 5'h00) begin
          rs_d = cmd_w[2:0];
          case (cmd_w[5:4])
            `ADCS_XFER_WRITE: begin
              state_d = LS_WRITE;
              cnt_d   = `ADCS_LEN_WRITE - 5'h01;
            end
            `ADCS_XFER_SINGLE, `ADCS_XFER_CONT: begin
              state_d = LS_READ;
              first_d = 1'b1;
              cont_d  = (cmd_w[5:4] == `ADCS_XFER_CONT);
              req_d   = ~req_q;
            end
            default: begin
              state_d = LS_CMD_WAIT;
              cont_d  = 1'b0;
            end
          endcase
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      LS_READ: begin
        hist_d = {hist_q[5:0], din};
        if (first_q) begin
          dout_d  = load_word[23];
          sh_d    = {load_word[22:0], 1'b0};
          cnt_d   = load_len - 5'h01;
          first_d = 1'b0;
        end else begin
          dout_d = sh_q[23];
          sh_d   = {sh_q[22:0], 1'b0};
          cnt_d  = cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            if (rs_q == `ADCS_SEL_DATA) begin
              rdd_d = ~rdd_q;
            end
            if (cont_q && ({hist_q, din} != `ADCS_STOP_CODE)) begin
              first_d = 1'b1;
              req_d   = ~req_q;
            end else begin
              state_d = LS_CMD_WAIT;
              cont_d  = 1'b0;
            end
          end
        end
      end
      LS_WRITE: begin
        if (cnt_q == 5'h00) begin
          state_d = LS_CMD_WAIT;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      default: state_d = LS_CMD_WAIT;
    endcase
  end

  // sequencer registers
  always_ff @(posedge sclk) begin
    if (!rst_s_q) begin
      state_q <= LS_CMD_WAIT;
      cmd_q   <= 7'h00;
      cnt_q   <= 5'h00;
      rs_q    <= 3'h0;
      cont_q  <= 1'b0;
      first_q <= 1'b0;
      sh_q    <= 24'h000000;
      hist_q  <= 7'h00;
      dout_q  <= 1'b0;
      req_q   <= 1'b0;
      rdd_q   <= 1'b0;
    end else if (ce_s_q) begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      rs_q    <= rs_d;
      cont_q  <= cont_d;
      first_q <= first_d;
      sh_q    <= sh_d;
      hist_q  <= hist_d;
      dout_q  <= dout_d;
      req_q   <= req_d;
      rdd_q   <= rdd_d;
    end
  end

  assign dout          = dout_q;
  assign snap_req_tgl  = req_q;
  assign data_read_tgl = rdd_q;

endmodule // adcs_link_port

// ===== adcs_status_top.sv
/*
  Converter status register with its serial read port. Tracks readiness,
  filter settling, standby and missing reference, loads the conversion
  data and calibration registers, and serves snapshots to the serial
  port running on the host's clock.
  Assumes the conversion and calibration engines run on ref_clk and give
  one-cycle pulses; low-power and reference-detector levels are
  asynchronous pins; the host leaves a gap of at least four ref_clk
  periods before the first clock of each read frame.
*/
`timescale 1ns/1ps
`include "adcs_params.svh"

module adcs_status_top
  import adcs_pkg::*;
#(
  parameter int         DATA_W       = 24,
  parameter logic [3:0] FACTORY_CODE = 4'h5  // arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout,
  output logic                   rdy_n,
  input  wire logic              low_power_req_n,
  input  wire logic              ref_missing_det,
  input  wire logic [2:0]        operating_mode_field,
  input  wire logic              word_length_24,
  input  wire logic              quick_step_mode,
  input  wire logic              result_write,
  input  wire logic [DATA_W-1:0] filter_result,
  input  wire logic              fir_settled,
  input  wire logic              ready_raise_event,
  input  wire logic              cal_done,
  input  wire logic              cal_gain_sel,
  input  wire logic [DATA_W-1:0] cal_result,
  output logic [DATA_W-1:0]      data_reg,
  output logic [DATA_W-1:0]      offset_reg,
  output logic [DATA_W-1:0]      gain_reg,
  output logic [7:0]             converter_status
);

  // ---------------------------------------------------------------
  // synchronisers for pins and for events from the serial domain
  // ---------------------------------------------------------------
  logic lp_m_q, lp_s_q;
  logic nr_m_q, nr_s_q;
  logic req_m_q, req_s_q, req_e_q;
  logic rdd_m_q, rdd_s_q, rdd_e_q;
  logic link_req_tgl, link_rdd_tgl;
  logic snap_take, data_read_done;

  // two flops for each crossing, a third to find toggles
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lp_m_q  <= 1'b1;
      lp_s_q  <= 1'b1;
      nr_m_q  <= 1'b0;
      nr_s_q  <= 1'b0;
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_e_q <= 1'b0;
      rdd_m_q <= 1'b0;
      rdd_s_q <= 1'b0;
      rdd_e_q <= 1'b0;
    end else if (ce) begin
      lp_m_q  <= low_power_req_n;
      lp_s_q  <= lp_m_q;
      nr_m_q  <= ref_missing_det;
      nr_s_q  <= nr_m_q;
      req_m_q <= link_req_tgl;
      req_s_q <= req_m_q;
      req_e_q <= req_s_q;
      rdd_m_q <= link_rdd_tgl;
      rdd_s_q <= rdd_m_q;
      rdd_e_q <= rdd_s_q;
    end
  end

  // toggles become one-cycle events
  assign snap_take      = req_s_q ^ req_e_q;
  assign data_read_done = rdd_s_q ^ rdd_e_q;

  // ---------------------------------------------------------------
  // readiness and filter-settled flags
  // ---------------------------------------------------------------
  logic ready_q, ready_d;      // 1 means no unread result
  logic settled_q, settled_d;  // 1 means filter not yet settled
  logic qs_used_q, qs_used_d;

  // next values of the two flags
  always_comb begin
    ready_d   = ready_q;
    settled_d = settled_q;
    qs_used_d = qs_used_q | quick_step_mode;
    if (data_read_done) begin
      ready_d = 1'b1;
      if (!qs_used_q) begin
        settled_d = 1'b0;
      end
    end
    if (result_write) begin
      ready_d = 1'b0;
      if (qs_used_d) begin
        settled_d = ~fir_settled;
      end
    end
    if (ready_raise_event) begin
      ready_d   = 1'b1;
      settled_d = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ready_q   <= `ADCS_RST_READY;
      settled_q <= `ADCS_RST_SETTLED;
      qs_used_q <= 1'b0;
    end else if (ce) begin
      ready_q   <= ready_d;
      settled_q <= settled_d;
      qs_used_q <= qs_used_d;
    end
  end

  // ---------------------------------------------------------------
  // standby and missing-reference flags
  // ---------------------------------------------------------------
  logic standby_q, standby_d;
  logic missing_reference_flag_q, missing_reference_flag_d;

  // level flags from pins and mode field
  always_comb begin
    standby_d = ~lp_s_q | (operating_mode_field == `ADCS_MODE_STANDBY);
    missing_reference_flag_d   = nr_s_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      standby_q <= `ADCS_RST_STANDBY;
      missing_reference_flag_q   <= `ADCS_RST_MISSING_REFERENCE_FLAG;
    end else if (ce) begin
      standby_q <= standby_d;
      missing_reference_flag_q   <= missing_reference_flag_d;
    end
  end

  // ---------------------------------------------------------------
  // conversion data and calibration registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] data_q, data_d;
  logic [DATA_W-1:0] offset_q, offset_d;
  logic [DATA_W-1:0] gain_q, gain_d;

  // result and calibration loading
  always_comb begin
    data_d   = data_q;
    offset_d = offset_q;
    gain_d   = gain_q;
    if (result_write) begin
      data_d = missing_reference_flag_q ? {DATA_W{1'b1}} : filter_result;
    end
    if (cal_done && !missing_reference_flag_q) begin
      if (cal_gain_sel) begin
        gain_d = cal_result;
      end else begin
        offset_d = cal_result;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_q   <= '0;
      offset_q <= '0;
      gain_q   <= '0;
    end else if (ce) begin
      data_q   <= data_d;
      offset_q <= offset_d;
      gain_q   <= gain_d;
    end
  end

  // ---------------------------------------------------------------
  // status byte and snapshot for the serial port
  // ---------------------------------------------------------------
  logic [7:0]        status_now;
  logic [7:0]        status_q;
  logic [7:0]        snap_status_q, snap_status_d;
  logic [DATA_W-1:0] snap_data_q, snap_data_d;
  logic              snap_wl_q, snap_wl_d;

  // assemble the live status byte
  always_comb begin
    status_now = 8'h00;
    status_now[`ADCS_BIT_READY]   = ready_q;
    status_now[`ADCS_BIT_SETTLED] = settled_q;
    status_now[`ADCS_BIT_STANDBY] = standby_q;
    status_now[`ADCS_BIT_MISSING_REFERENCE_FLAG]   = missing_reference_flag_q;
    status_now[3:0] = FACTORY_CODE;
  end

  // snapshot held still between requests
  always_comb begin
    snap_status_d = snap_status_q;
    snap_data_d   = snap_data_q;
    snap_wl_d     = snap_wl_q;
    if (snap_take) begin
      snap_status_d = status_now;
      snap_data_d   = data_q;
      snap_wl_d     = word_length_24;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_q      <= {`ADCS_RST_READY, `ADCS_RST_SETTLED, `ADCS_RST_STANDBY,
                        `ADCS_RST_MISSING_REFERENCE_FLAG, FACTORY_CODE};
      snap_status_q <= 8'h00;
      snap_data_q   <= '0;
      snap_wl_q     <= 1'b1;
    end else if (ce) begin
      status_q      <= status_now;
      snap_status_q <= snap_status_d;
      snap_data_q   <= snap_data_d;
      snap_wl_q     <= snap_wl_d;
    end
  end

  // ---------------------------------------------------------------
  // serial port on the host clock
  // ---------------------------------------------------------------
  adcs_link_port #(
    .DATA_W (DATA_W)
  ) u_link (
    .sclk          (sclk),
    .resetn        (resetn),
    .ce            (ce),
    .din           (din),
    .dout          (dout),
    .snap_status   (snap_status_q),
    .snap_data     (snap_data_q),
    .snap_wl24     (snap_wl_q),
    .snap_req_tgl  (link_req_tgl),
    .data_read_tgl (link_rdd_tgl)
  );

  // outputs straight from registers
  assign rdy_n            = ready_q;
  assign data_reg         = data_q;
  assign offset_reg       = offset_q;
  assign gain_reg         = gain_q;
  assign converter_status = status_q;

endmodule // adcs_status_top

// ===== adcs_status_monitor.sv
/*
  Checker for the converter status register, watching top ports only.
  Assumes ce drops only while level inputs are steady; resetn is synchronous.
*/
`timescale 1ns/1ps
module adcs_status_monitor
  import adcs_pkg::*;
#(
  parameter int         DATA_W       = 24,
  parameter logic [3:0] FACTORY_CODE = 4'h5  // arbitrary value
) (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              ce,
  input wire logic              rdy_n,
  input wire logic              low_power_req_n,
  input wire logic              ref_missing_det,
  input wire logic [2:0]        operating_mode_field,
  input wire logic              result_write,
  input wire logic [DATA_W-1:0] filter_result,
  input wire logic              ready_raise_event,
  input wire logic              cal_done,
  input wire logic [DATA_W-1:0] data_reg,
  input wire logic [DATA_W-1:0] offset_reg,
  input wire logic [DATA_W-1:0] gain_reg,
  input wire logic [7:0]        converter_status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // reference level held long enough to pass the synchroniser
  sequence ref_lost;
    ref_missing_det [*4];
  endsequence
  sequence ref_ok;
    !ref_missing_det [*4];
  endsequence

  a_reset_status: assert property (
    $rose(resetn) |-> converter_status == {4'hc, FACTORY_CODE})
    else $error("status wrong after reset");
  a_ready_mirror: assert property (
    converter_status[7] == $past(rdy_n))
    else $error("ready bit differs from pin");
  a_result_ready: assert property (
    (result_write && ce && !ready_raise_event) |=> !rdy_n)
    else $error("new result left ready high");
  a_result_data: assert property (
    ref_ok ##0 (result_write && ce) |=> data_reg == $past(filter_result))
    else $error("data register not loaded");
  a_lost_ones: assert property (
    ref_lost ##0 (result_write && ce) |=> &data_reg)
    else $error("data not all ones without reference");
  a_cal_hold: assert property (
    ref_lost ##0 (cal_done && ce) |=> $stable(offset_reg) && $stable(gain_reg))
    else $error("calibration updated without reference");
  a_standby_mode: assert property (
    (operating_mode_field == 3'h3) [*4] |-> converter_status[5])
    else $error("standby bit low in standby mode");
  a_standby_pin: assert property (
    (!low_power_req_n) [*6] |-> converter_status[5])
    else $error("standby bit low with pin request");
  a_awake_clear: assert property (
    (low_power_req_n && operating_mode_field != 3'h3) [*6] |-> !converter_status[5])
    else $error("standby bit high while awake");
  a_ref_flag: assert property (
    $stable(ref_missing_det) [*6] |-> converter_status[4] == ref_missing_det)
    else $error("reference bit differs from detector");
  a_factory_code: assert property (
    converter_status[3:0] == FACTORY_CODE)
    else $error("factory nibble changed");
  a_settled_rise: assert property (
    $rose(converter_status[6]) |-> $past(ready_raise_event, 2) || $past(result_write, 2))
    else $error("settled bit rose without cause");
  a_raise_both: assert property (
    (ready_raise_event && ce) |=> rdy_n ##1 converter_status[7:6] == 2'b11)
    else $error("raise event missed a flag");
endmodule // adcs_status_monitor

bind adcs_status_top adcs_status_monitor #(
  .DATA_W(DATA_W), .FACTORY_CODE(FACTORY_CODE)
) adcs_status_monitor_i (
  .ref_clk, .resetn, .ce, .rdy_n, .low_power_req_n, .ref_missing_det,
  .operating_mode_field, .result_write, .filter_result, .ready_raise_event,
  .cal_done, .data_reg, .offset_reg, .gain_reg, .converter_status
);

// ===== adcs_host_model.sv
/*
  Host serial master: sends command words and runs read frames.
  Assumes the device samples din on rising sclk and drives dout after it.
*/
`timescale 1ns/1ps
module adcs_host_model (
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  // serial clock rests low outside frames
  initial begin
    sclk = 1'b0;
    din  = 1'b1;
  end
  // one frame of n clocks, msb first, 48 ns period, gap before it
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] r);
    r = '0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      r[i] = dout;
    end
    din = ~din;  // inverted last bit, not the last value
  endtask
  task automatic command(input logic [7:0] c);
    logic [23:0] r;
    frame({16'h0, c}, 8, r);
  endtask
  task automatic read(input int n, input logic stop, output logic [23:0] r);
    frame(stop ? 24'h30 : 24'h0, n, r);
  endtask
endmodule // adcs_host_model

// ===== adcs_status_top_tb.sv
/*
  Testbench for the converter status register: core events and serial reads.
  Assumes adcs_host_model stands for the host on the serial port.
*/
`timescale 1ns/1ps
module adcs_status_top_tb;
  import adcs_pkg::*;
  localparam logic [3:0] FC = 4'ha;  // arbitrary factory code
  logic        ref_clk              = 1'b0;
  logic        resetn               = 1'b0;
  logic        ce                   = 1'b1;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        rdy_n;
  logic        low_power_req_n      = 1'b1;
  logic        ref_missing_det      = 1'b0;
  logic [2:0]  operating_mode_field = 3'h0;
  logic        word_length_24       = 1'b1;
  logic        quick_step_mode      = 1'b0;
  logic        result_write         = 1'b0;
  logic [23:0] filter_result        = 24'h0;
  logic        fir_settled          = 1'b0;
  logic        ready_raise_event    = 1'b0;
  logic        cal_done             = 1'b0;
  logic        cal_gain_sel         = 1'b0;
  logic [23:0] cal_result           = 24'h0;
  logic [23:0] data_reg, offset_reg, gain_reg, rx;
  logic [7:0]  converter_status;
  int          num_errors           = 0;
  int          n_compared           = 0;

  // core clock, 25 ns
  always #12.5 ref_clk = ~ref_clk;

  adcs_status_top #(.DATA_W(24), .FACTORY_CODE(FC)) adcs_status_top_i (
    .ref_clk, .resetn, .ce, .sclk, .din, .dout, .rdy_n, .low_power_req_n,
    .ref_missing_det, .operating_mode_field, .word_length_24, .quick_step_mode,
    .result_write, .filter_result, .fir_settled, .ready_raise_event, .cal_done,
    .cal_gain_sel, .cal_result, .data_reg, .offset_reg, .gain_reg,
    .converter_status
  );
  adcs_host_model adcs_host_model_i (.sclk, .din, .dout);

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // inputs change 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic fetch(input logic [7:0] c, input int n, input logic [23:0] exp);
    adcs_host_model_i.command(c);
    adcs_host_model_i.read(n, 1'b0, rx);
    chk("serial", rx, exp);
    step(1);
  endtask
  task automatic st(input logic [3:0] hi);
    chk("status", {16'h0, converter_status}, {16'h0, hi, FC});
    fetch(8'h10, 8, {16'h0, hi, FC});
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    while (rdy_n !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    chk("rdy_n", rdy_n, 1'b1);
    if (rdy_n !== 1'b1) report_and_stop();
    step(2);
  endtask
  task automatic result(input logic [23:0] v, input logic s);
    filter_result = v;
    fir_settled = s;
    result_write = 1'b1;
    step(1);
    result_write = 1'b0;
    step(3);
  endtask
  task automatic raise;
    ready_raise_event = 1'b1;
    step(1);
    ready_raise_event = 1'b0;
    step(3);
  endtask
  task automatic cal(input logic g, input logic [23:0] v);
    cal_gain_sel = g;
    cal_result = v;
    cal_done = 1'b1;
    step(1);
    cal_done = 1'b0;
    step(2);
  endtask

  // main sequence
  initial begin
    step(1);
    adcs_host_model_i.frame(24'hffffff, 8, rx);  // serial side reset edges
    step(1);
    resetn = 1'b1;
    adcs_host_model_i.frame(24'hffffff, 8, rx);
    step(1);
    chk("rdy_n", rdy_n, 1'b1);
    chk("data", data_reg, 24'h0);
    st(4'hc);
    result(24'h123456, 1'b0);
    chk("rdy_n", rdy_n, 1'b0);
    chk("data", data_reg, 24'h123456);
    st(4'h4);
    fetch(8'h11, 24, 24'h123456);
    wait_rdy();
    st(4'h8);
    result(24'habcdef, 1'b0);
    word_length_24 = 1'b0;
    fetch(8'h11, 16, 24'h00abcd);
    wait_rdy();
    st(4'h8);
    raise();
    st(4'hc);
    quick_step_mode = 1'b1;
    word_length_24 = 1'b1;
    result(24'h000001, 1'b0);
    st(4'h4);
    result(24'h000002, 1'b1);
    st(4'h0);
    fetch(8'h11, 24, 24'h000002);
    wait_rdy();
    st(4'h8);
    operating_mode_field = 3'h3;
    step(6);
    chk("standby", converter_status[5], 1'b1);
    operating_mode_field = 3'h1;
    low_power_req_n = 1'b0;
    step(6);
    chk("standby", converter_status[5], 1'b1);
    low_power_req_n = 1'b1;
    step(6);
    chk("standby", converter_status[5], 1'b0);
    ref_missing_det = 1'b1;
    step(6);
    chk("missing_reference_flag", converter_status[4], 1'b1);
    result(24'h000111, 1'b1);
    chk("data", data_reg, 24'hffffff);
    cal(1'b1, 24'h55aa55);
    chk("gain", gain_reg, 24'h0);
    ref_missing_det = 1'b0;
    step(6);
    chk("missing_reference_flag", converter_status[4], 1'b0);
    cal(1'b1, 24'h55aa55);
    chk("gain", gain_reg, 24'h55aa55);
    cal(1'b0, 24'h0a0b0c);
    chk("offset", offset_reg, 24'h0a0b0c);
    adcs_host_model_i.command(8'h20);
    adcs_host_model_i.read(8, 1'b0, rx);
    chk("stream", rx, {16'h0, 4'h0, FC});
    adcs_host_model_i.read(8, 1'b1, rx);
    chk("stream", rx, {16'h0, 4'h0, FC});
    step(1);
    fetch(8'h11, 24, 24'hffffff);
    wait_rdy();
    // write payload is skipped, then the port waits for a command again
    adcs_host_model_i.command(8'h02);
    adcs_host_model_i.frame(24'h005a5a, 16, rx);
    fetch(8'h10, 8, {16'h0, 4'h8, FC});
    fetch(8'h12, 16, 24'h0);
    // stop code outside a stream leaves the port in command wait
    adcs_host_model_i.command(8'h30);
    fetch(8'h10, 8, {16'h0, 4'h8, FC});
    // clock enable low freezes the flags and the data register
    ce = 1'b0;
    result(24'h0c0c0c, 1'b0);
    chk("rdy_n", rdy_n, 1'b1);
    chk("data", data_reg, 24'hffffff);
    ce = 1'b1;
    result(24'h0c0c0c, 1'b0);
    chk("rdy_n", rdy_n, 1'b0);
    chk("data", data_reg, 24'h0c0c0c);
    report_and_stop();
  end
endmodule // adcs_status_top_tb
